// >>> sarcv_cfg.svh
// Constants for the converter setup and readout block
`ifndef SARCV_CFG_SVH
`define SARCV_CFG_SVH
`define SARCV_SETUP_W 12
`define SARCV_SETUP_RST 12'hFFF
`define SARCV_BIT_CONVERSION_CLOCK 10
`define SARCV_BIT_TRIG 9
`define SARCV_BIT_CHAIN 5
`define SARCV_BIT_ANAP 4
`define SARCV_BIT_NAP 3
`define SARCV_BIT_DEEP 2
`define SARCV_BIT_TAG 1
`define SARCV_BIT_SWRST 0
`define SARCV_CMD_WAKE 4'hB
`define SARCV_CMD_RDSETUP 4'hC
`define SARCV_CMD_RDDATA 4'hD
`define SARCV_CMD_WRSETUP 4'hE
`define SARCV_CMD_DEFAULT 4'hF
`define SARCV_CMD_BITS 5'h04
`define SARCV_FRAME_BITS 5'h10
`define SARCV_TAG_POS 5'h10
`define SARCV_CHAIN_PLAIN 5'h10
`define SARCV_CHAIN_TAG 5'h18
`define SARCV_EOS_CCLKS 2'h3
`define SARCV_CONV_CCLKS 6'h0C
`define SARCV_CONVERSION_CLOCK_DIV 2'h2
`endif

// >>> sarcv_fifo.sv
// Small synchronous FIFO carrying finished results to the readout
`timescale 1ns/1ps
module sarcv_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [WIDTH-1:0] dout_q;
  logic have_q;
  logic empty;
  logic pop;

  // Full and empty from pointers with one wrap bit
  assign empty = (wr_q == rd_q);
  assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
                      (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = have_q;
  assign out_data = dout_q;
  assign pop = !empty && (!have_q || out_ready);

  // Storage write
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

  // Pointers and registered read stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      have_q <= 1'b0;
      dout_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
        dout_q <= mem_q[rd_q[AW-1:0]];
        have_q <= 1'b1;
      end
      else if (out_ready)
        have_q <= 1'b0;
    end
  end
endmodule // sarcv_fifo

// >>> sarcv_host.sv
// Host controller model driving the serial frame pins of the converter
`timescale 1ns/1ps
module sarcv_host (
  input wire logic clk,
  input wire logic serial_result_out,
  input wire logic sdo_oe,
  output logic sclk,
  output logic fs_n,
  output logic serial_command_in,
  output logic chain_data_input
);
  // Idle pins; serial clock stands still high between frames
  initial
  begin
    sclk = 1'b1;
    fs_n = 1'b1;
    serial_command_in = 1'b0;
    chain_data_input = 1'b0;
  end

  // One frame of n clocks, MSB first, four system cycles per half period
  task automatic frame(input int n, input logic [47:0] tx,
    input logic [47:0] ctx, output logic [47:0] rx, output logic oe_all);
    rx = '0;
    oe_all = 1'b1;
    @(negedge clk);
    fs_n = 1'b0;
    repeat (8) @(negedge clk);
    // marker clocks: caller asks above 16 clocks when tag is on
    for (int i = 0; i < n; i++)
    begin
      rx = {rx[46:0], serial_result_out}; // Bit settled well after the previous fall
      oe_all = oe_all & sdo_oe;
      serial_command_in = tx[n-1-i];
      chain_data_input = ctx[n-1-i];
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
    end
    repeat (8) @(negedge clk);
    fs_n = 1'b1;
    // Released lines flip so a stale level never passes for data
    serial_command_in = ~serial_command_in;
    chain_data_input = ~chain_data_input;
    repeat (8) @(negedge clk);
  endtask
endmodule // sarcv_host

// >>> sarcv_pkg.sv
// Types shared by the converter setup and readout block
package sarcv_pkg;
  typedef logic [11:0] sarcv_result_t;
  typedef logic [11:0] sarcv_setup_t;
  typedef enum logic [1:0] {
    SARCV_IDLE = 2'b00,
    SARCV_SAMPLE = 2'b01,
    SARCV_CONVERT = 2'b10
  } sarcv_conv_e;
endpackage

// >>> sarcv_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sarcv_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // sarcv_sync

// >>> sarcv_top.sv
// Setup register and serial result readout of a 12-bit converter
//
// Operation
// - Setup bit 5 low makes status pin chain input; high makes it EOC.
// - Bit 4 low enables auto nap; ignored while trigger bit 9 is 0.
// - Bit 3 low puts device in nap power-down; high resumes.
// - Bit 2 low puts device in deep power-down; high resumes.
// - Wake-up command forces nap and deep power-down bits to 1.
// - Bit 1 enables channel marker at 17th clock; single variant reads 0.
// - Writing 0 to bit 0 resets like power-on; all bits return to 1.
// - Result loads at end of conversion, shown at next select fall.
// - Sampling ends at trigger fall, or third conversion clock in auto.
// - Select before conversion end gives previous, after gives current.
// - Result is 12-bit straight binary.
// - MSB first, then four zeros, marker if enabled, then zeros.
// - Serial output driven only while select low; released on rise.
// - Every driven frame shifts leading result bits, also command frames.
// - First frame after any reset shifts all ones.
// - Marker bit is 0 for channel 0, 1 for channel 1.
// - Chain mode passes chain input to output after 16 or 24 clocks.
`timescale 1ns/1ps
`include "sarcv_cfg.svh"
module sarcv_top #(
  parameter bit DUAL_CHANNEL = 1'b1,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic SCLK,
  input wire logic FRAME_SYNC_N,
  input wire logic SERIAL_COMMAND_IN,
  input wire logic SAMPLE_HOLD_TRIGGER_N,
  input wire logic CHAIN_DATA_INPUT,
  input wire logic CONV_CHANNEL,
  input wire sarcv_pkg::sarcv_result_t CONV_RESULT,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  output logic EOC_N,
  output logic CONV_START,
  output logic NAP_ACTIVE,
  output logic DEEP_ACTIVE,
  output logic [11:0] SETUP_VALUE
);
  import sarcv_pkg::*;
  default clocking sarcv_cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  logic [4:0] pins_s;
  logic sclk_s, fs_s, sdi_s, trig_s, cdi_s;
  logic sclk_p, fs_p, trig_p;
  logic sclk_fall, fs_fall, trig_fall;
  sarcv_setup_t setup_q;
  logic sw_rst;
  logic [15:0] cmd_sr_q;
  logic [4:0] bitcnt_q;
  logic [23:0] out_sr_q;
  logic after_rst_q;
  sarcv_conv_e conv_q;
  logic [5:0] cnt_q;
  logic [1:0] cdiv_q;
  logic conversion_clock_tick;
  logic eoc_pulse;
  logic fifo_in_ready, fifo_valid;
  logic [12:0] fifo_data;
  logic [12:0] latest_q;
  logic chain_on, tag_on, auto_nap;
  logic [4:0] chain_len, chain_pos;

  // Pins pass two flops; idle-high pins go in inverted so reset reads idle
  sarcv_sync #(.WIDTH(5)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .din({~SCLK, ~FRAME_SYNC_N, SERIAL_COMMAND_IN, ~SAMPLE_HOLD_TRIGGER_N,
          CHAIN_DATA_INPUT}),
    .dout(pins_s)
  );
  assign {sclk_s, fs_s, sdi_s, trig_s, cdi_s} = pins_s ^ 5'h1A;

  // Edge detectors on synchronised levels
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sclk_p <= 1'b1;
      fs_p <= 1'b1;
      trig_p <= 1'b1;
    end
    else
    begin
      sclk_p <= sclk_s;
      fs_p <= fs_s;
      trig_p <= trig_s;
    end
  end
  assign sclk_fall = !sclk_s && sclk_p && !fs_s;
  assign fs_fall = !fs_s && fs_p;
  assign trig_fall = !trig_s && trig_p;

  assign chain_on = !setup_q[`SARCV_BIT_CHAIN];
  assign tag_on = DUAL_CHANNEL && setup_q[`SARCV_BIT_TAG];
  // auto nap only under manual trigger
  assign auto_nap = setup_q[`SARCV_BIT_TRIG] && !setup_q[`SARCV_BIT_ANAP];
  assign chain_len = tag_on ? `SARCV_CHAIN_TAG : `SARCV_CHAIN_PLAIN;
  // Chain bits enter where they leave after chain_len clocks
  assign chain_pos = `SARCV_CHAIN_TAG - chain_len;
  // software reset bit acts as a reset
  assign sw_rst = !setup_q[`SARCV_BIT_SWRST];

  // Command shift and bit counter, sampled on serial clock falls
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cmd_sr_q <= '0;
      bitcnt_q <= '0;
    end
    else if (fs_s)
      bitcnt_q <= '0;
    else if (sclk_fall)
    begin
      cmd_sr_q <= {cmd_sr_q[14:0], sdi_s};
      if (bitcnt_q != 5'h1F)
        bitcnt_q <= bitcnt_q + 5'h01;
    end
  end

  // Setup register; commands take effect on 4th or 16th fall
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      setup_q <= `SARCV_SETUP_RST;
    // reset returns all bits to one
    else if (sw_rst)
      setup_q <= `SARCV_SETUP_RST;
    else if (sclk_fall)
    begin
      if (bitcnt_q == `SARCV_CMD_BITS - 5'h01)
      begin
        if ({cmd_sr_q[2:0], sdi_s} == `SARCV_CMD_WAKE)
        begin
          setup_q[`SARCV_BIT_NAP] <= 1'b1;
          setup_q[`SARCV_BIT_DEEP] <= 1'b1;
        end
        else if ({cmd_sr_q[2:0], sdi_s} == `SARCV_CMD_DEFAULT)
          setup_q <= `SARCV_SETUP_RST;
      end
      else if (bitcnt_q == `SARCV_FRAME_BITS - 5'h01 &&
               cmd_sr_q[14:11] == `SARCV_CMD_WRSETUP)
        setup_q <= {cmd_sr_q[10:0], sdi_s};
    end
  end

  assign NAP_ACTIVE = !setup_q[`SARCV_BIT_NAP] || auto_nap;
  assign DEEP_ACTIVE = !setup_q[`SARCV_BIT_DEEP];
  // marker bit reads zero on single variant
  assign SETUP_VALUE = DUAL_CHANNEL ? setup_q :
                       (setup_q & ~(12'h001 << `SARCV_BIT_TAG));

  // Conversion clock from internal divider or serial clock over two
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      cdiv_q <= '0;
    else if (setup_q[`SARCV_BIT_CONVERSION_CLOCK])
      cdiv_q <= (cdiv_q == `SARCV_CONVERSION_CLOCK_DIV - 2'h1) ? 2'h0 : cdiv_q + 2'h1;
    else if (sclk_s && !sclk_p)
      cdiv_q <= cdiv_q ^ 2'h1;
  end
  assign conversion_clock_tick = setup_q[`SARCV_BIT_CONVERSION_CLOCK] ? (cdiv_q == 2'h0)
                     : (sclk_s && !sclk_p && cdiv_q[0]);

  // Conversion sequencer: end of sampling then fixed conversion count
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      conv_q <= SARCV_IDLE;
      cnt_q <= '0;
    end
    else if (sw_rst || DEEP_ACTIVE)
    begin
      conv_q <= SARCV_IDLE;
      cnt_q <= '0;
    end
    else
      unique case (conv_q)
        SARCV_IDLE:
        begin
          // manual end of sampling on trigger fall
          if (setup_q[`SARCV_BIT_TRIG] && trig_fall)
          begin
            conv_q <= SARCV_CONVERT;
            cnt_q <= '0;
          end
          else if (!setup_q[`SARCV_BIT_TRIG])
          begin
            conv_q <= SARCV_SAMPLE;
            cnt_q <= '0;
          end
        end
        SARCV_SAMPLE:
          // auto end of sampling after third conversion clock
          if (conversion_clock_tick)
          begin
            if (cnt_q[1:0] == `SARCV_EOS_CCLKS - 2'h1)
            begin
              conv_q <= SARCV_CONVERT;
              cnt_q <= '0;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          end
        SARCV_CONVERT:
          if (conversion_clock_tick)
          begin
            if (cnt_q == `SARCV_CONV_CCLKS - 6'h01)
            begin
              conv_q <= SARCV_IDLE;
              cnt_q <= '0;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          end
        default:
          conv_q <= SARCV_IDLE;
      endcase
  end
  assign eoc_pulse = (conv_q == SARCV_CONVERT) && conversion_clock_tick &&
                     (cnt_q == `SARCV_CONV_CCLKS - 6'h01);
  assign CONV_START = (conv_q != SARCV_CONVERT);
  // status pin acts as end-of-conversion only outside chain mode
  assign EOC_N = chain_on ? 1'b1 : (conv_q == SARCV_CONVERT);

  // result with channel enters the queue at conversion end
  sarcv_fifo #(.WIDTH(13), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .in_valid(eoc_pulse),
    .in_ready(fifo_in_ready),
    .in_data({CONV_CHANNEL, CONV_RESULT}),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  // Newest result kept; a select fall takes whatever has arrived so far
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      latest_q <= '0;
    else if (fifo_valid)
      latest_q <= fifo_data;
  end

  // all ones on first frame after any reset
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      after_rst_q <= 1'b1;
    else if (sw_rst)
      after_rst_q <= 1'b1;
    else if (fs_fall)
      after_rst_q <= 1'b0; // A reset inside a frame still marks the next
  end

  // Output shifter; loaded on select fall, shifted on serial clock falls
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      out_sr_q <= '1;
    else if (fs_fall)
    begin
      if (after_rst_q)
        out_sr_q <= '1;
      else
        out_sr_q <= {latest_q[11:0], 4'h0, tag_on & latest_q[12], 7'h00};
    end
    // each clock moves next bit, chain input fills behind
    else if (sclk_fall)
    begin
      out_sr_q <= {out_sr_q[22:0], out_sr_q[0]}; // Ones or zeros persist
      if (chain_on)
        out_sr_q[chain_pos] <= cdi_s;
    end
  end

  // drive only while select is low
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SERIAL_RESULT_OUT <= 1'b0;
      SERIAL_RESULT_OE <= 1'b0;
    end
    else
    begin
      SERIAL_RESULT_OE <= !fs_s;
      SERIAL_RESULT_OUT <= !fs_s && out_sr_q[23];
    end
  end

  // Checks on select, setup handling, frame contents and the result queue
  a_oe_follows_fs: assert property (fs_s |=> !SERIAL_RESULT_OE)
    else $error("serial output driven while select high");
  a_wake_sets_pwr: assert property (
    (sclk_fall && bitcnt_q == 5'h03 && !sw_rst &&
     {cmd_sr_q[2:0], sdi_s} == `SARCV_CMD_WAKE)
    |=> setup_q[3] && setup_q[2])
    else $error("wake-up did not clear power-down");
  a_swrst_default: assert property (
    sw_rst |=> setup_q == `SARCV_SETUP_RST && after_rst_q)
    else $error("software reset did not restore defaults");
  a_first_ones: assert property (
    (fs_fall && after_rst_q) |=> out_sr_q == 24'hFFFFFF)
    else $error("first frame after reset not all ones");
  a_frame_layout: assert property (
    (fs_fall && !after_rst_q) |=>
    out_sr_q[23:12] == $past(latest_q[11:0]) && out_sr_q[11:8] == 4'h0)
    else $error("frame layout wrong");
  a_tag_gate: assert property (
    (fs_fall && !after_rst_q && !tag_on) |=> out_sr_q[7] == 1'b0)
    else $error("marker bit present while disabled");
  a_deep_idle: assert property (
    DEEP_ACTIVE |=> conv_q == SARCV_IDLE)
    else $error("conversion running in deep power-down");
  a_anap_ignored: assert property (
    (!setup_q[9] && setup_q[3]) |-> !NAP_ACTIVE)
    else $error("auto nap active under auto trigger");
  a_fifo_room: assert property (eoc_pulse |-> fifo_in_ready)
    else $error("finished result found the queue full");
endmodule // sarcv_top

// >>> tb_top.sv
// Self-checking bench for the converter setup and readout block
`timescale 1ns/1ps
module tb_top;
  import sarcv_pkg::*;
  logic clk_sys, rstn, sclk, fs_n, serial_command_in, chain_data_input, trig_n, chan;
  logic serial_result_out, sdo_oe, eoc_n, conv_start, nap, deep, oe_all;
  logic [11:0] setup;
  logic [47:0] rx;
  sarcv_result_t res;
  sarcv_result_t vals [4] = '{12'h000, 12'h800, 12'h7FF, 12'hFFF};
  int err_count = 0;
  int n_checks = 0;

  // Device under test, dual channel so the marker is live
  sarcv_top #(.DUAL_CHANNEL(1'b1), .FIFO_DEPTH(16)) sarcv_top_inst (
    .CLK_SYS(clk_sys), .RSTN(rstn), .SCLK(sclk), .FRAME_SYNC_N(fs_n),
    .SERIAL_COMMAND_IN(serial_command_in), .SAMPLE_HOLD_TRIGGER_N(trig_n),
    .CHAIN_DATA_INPUT(chain_data_input), .CONV_CHANNEL(chan), .CONV_RESULT(res),
    .SERIAL_RESULT_OUT(serial_result_out), .SERIAL_RESULT_OE(sdo_oe), .EOC_N(eoc_n),
    .CONV_START(conv_start), .NAP_ACTIVE(nap), .DEEP_ACTIVE(deep),
    .SETUP_VALUE(setup));

  // Host side of the serial port
  sarcv_host sarcv_host_inst (.clk(clk_sys), .serial_result_out(serial_result_out), .sdo_oe(sdo_oe),
    .sclk(sclk), .fs_n(fs_n), .serial_command_in(serial_command_in), .chain_data_input(chain_data_input));

  // System clock, 40 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Four-state comparison with report
  task automatic check(input string name, input logic [47:0] seen,
    input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait on the conversion state; a hang ends the run
  task automatic wait_conv(input logic want);
    int i;
    for (i = 0; i < 400 && conv_start !== want; i++)
      @(negedge clk_sys);
    if (i == 400)
    begin
      err_count++;
      $display("Error conversion wait expected %b seen %b", want, conv_start);
      stop_test();
    end
  endtask

  // Frame helpers: data read, setup write, short command
  task automatic rd(input int n);
    sarcv_host_inst.frame(n, 48'hD << (n - 4), 48'h0, rx, oe_all);
  endtask

  task automatic wr(input logic [11:0] v);
    sarcv_host_inst.frame(16, {32'h0, 4'hE, v}, 48'h0, rx, oe_all);
  endtask

  task automatic cmd(input logic [3:0] c);
    sarcv_host_inst.frame(4, {44'h0, c}, 48'h0, rx, oe_all);
  endtask

  // quiet zone: select is high around every trigger fall
  task automatic trig(input sarcv_result_t v, input logic c);
    @(negedge clk_sys);
    res = v;
    chan = c;
    trig_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    trig_n = 1'b1;
    wait_conv(1'b0);
  endtask

  // select spacing: a few cycles pass after conversion end
  task automatic convert(input sarcv_result_t v, input logic c);
    trig(v, c);
    wait_conv(1'b1);
    repeat (4) @(negedge clk_sys);
  endtask

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    trig_n = 1'b1;
    chan = 1'b0;
    res = 12'h000;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("setup reset", 48'(setup), 48'hFFF);
    rd(16);
    check("first frame", rx, 48'hFFFF);
    check("oe in frame", 48'(oe_all), 48'h1);
    check("oe released", 48'(sdo_oe), 48'h0);
    wr(12'hFF3);
    check("setup nap deep", 48'(setup), 48'hFF3);
    check("nap on", 48'(nap), 48'h1);
    check("deep on", 48'(deep), 48'h1);
    cmd(4'hB);
    check("wake setup", 48'(setup), 48'hFFF);
    check("nap off", 48'(nap), 48'h0);
    check("deep off", 48'(deep), 48'h0);
    for (int j = 0; j < 4; j++)
    begin
      convert(vals[j], j[0]);
      rd(24);
      check("result", rx, 48'({vals[j], 4'h0, j[0], 7'h0}));
    end
    convert(12'h5A3, 1'b0);
    trig(12'h3C6, 1'b1);
    rd(24);
    check("previous", rx, 48'({12'h5A3, 12'h0}));
    wait_conv(1'b1);
    repeat (4) @(negedge clk_sys);
    cmd(4'h0);
    check("short frame", rx, 48'h3);
    wr(12'hFFD);
    rd(24);
    check("no marker", rx, 48'({12'h3C6, 12'h0}));
    wr(12'hFDF);
    check("eoc chain", 48'(eoc_n), 48'h1);
    sarcv_host_inst.frame(48, 48'hD << 44, {24'hA5C3F0, 24'h0}, rx,
      oe_all);
    check("chain", rx, {12'h3C6, 5'h1, 7'h0, 24'hA5C3F0});
    wr(12'hFDD);
    sarcv_host_inst.frame(32, 48'hD << 28, {16'h0, 16'h9E1B, 16'h0}, rx,
      oe_all);
    check("chain short", rx, 48'({12'h3C6, 4'h0, 16'h9E1B}));
    cmd(4'hF);
    check("default cmd", 48'(setup), 48'hFFF);
    check("eoc idle", 48'(eoc_n), 48'h0);
    // auto nap obeys only under manual trigger
    wr(12'hFEF);
    check("auto nap", 48'(nap), 48'h1);
    wr(12'hDEF);
    check("auto nap ignored", 48'(nap), 48'h0);
    wr(12'hFFE);
    check("soft reset", 48'(setup), 48'hFFF);
    rd(16);
    check("frame after soft", rx, 48'hFFFF);
    stop_test();
  end
endmodule // tb_top
